// file: design/rrfi_defs.svh
`ifndef RRFI_DEFS_SVH
`define RRFI_DEFS_SVH
// ==========================================
// status and event layout
`define RRFI_MAV_BIT     4
`define RRFI_PON_BIT     7
`define RRFI_SB_RST      8'h00
`define RRFI_EVT_RST     8'h80
`define RRFI_ENA_RST     8'h00
`define RRFI_HDR_RST     1'b0
`define RRFI_PATH_RST    4'h0
// ==========================================
// reply field shapes
`define RRFI_DIGITS      6
`define RRFI_D_FRAC      5
`define RRFI_DQ_FRAC     1
`define RRFI_PCT_FRAC    2
`define RRFI_PCT_DIGITS  5
`define RRFI_EXP_DIGITS  2
`define RRFI_MAX_CHARS   12
`define RRFI_CH_ZERO     8'h30
`define RRFI_CH_MINUS    8'h2d
`define RRFI_CH_PLUS     8'h2b
`define RRFI_CH_POINT    8'h2e
`define RRFI_CH_EXP      8'h45
`endif

// file: design/rrfi_pkg.sv
package rrfi_pkg;
  // ==========================================
  // reply field kinds
  typedef enum logic [2:0] {
    RRFI_LOAD_COEF = 3'h0,
    RRFI_LOAD_D    = 3'h1,
    RRFI_C_OFFSET  = 3'h2,
    RRFI_DQ_OFFSET = 3'h3,
    RRFI_PCT_C     = 3'h4,
    RRFI_PCT_D     = 3'h5,
    RRFI_COUNT     = 3'h6
  } rrfi_kind_e;

  typedef enum logic [1:0] {
    RRFI_IDLE = 2'h1,
    RRFI_SEND = 2'h2
  } rrfi_state_e;

  // one value to be formatted
  typedef struct packed {
    rrfi_kind_e  kind;
    logic        neg;
    logic [23:0] digits;
    logic [2:0]  dp_pos;
    logic        exp_neg;
    logic [7:0]  exponent;
  } rrfi_value_s;

  // one character of the reply
  typedef struct packed {
    logic [7:0] ch;
    logic       last;
  } rrfi_char_s;

  // initialization events
  typedef struct packed {
    logic power_on;
    logic rst_cmd;
    logic cls_cmd;
    logic dev_clr;
  } rrfi_init_s;
endpackage : rrfi_pkg

// file: design/rrfi_top.sv
`timescale 1ns/1ps
`include "rrfi_defs.svh"
module rrfi_top #(
  parameter int PATH_W = 4
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire rrfi_pkg::rrfi_init_s init,
  input  wire logic [7:0]           sb_set,
  input  wire logic [7:0]           evt_set,
  input  wire logic                 sre_we,
  input  wire logic                 ese_we,
  input  wire logic [7:0]           ena_wdata,
  input  wire logic                 hdr_we,
  input  wire logic                 hdr_wdata,
  input  wire logic                 path_we,
  input  wire logic [PATH_W-1:0]    path_wdata,
  input  wire logic                 fmt_valid,
  output logic                      fmt_ready,
  input  wire rrfi_pkg::rrfi_value_s fmt_value,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output rrfi_pkg::rrfi_char_s      out_char,
  output logic [7:0]                status_byte_r,
  output logic [7:0]                event_r,
  output logic [7:0]                sre_r,
  output logic [7:0]                ese_r,
  output logic                      header_r,
  output logic [PATH_W-1:0]         path_r,
  output logic                      oq_flush_r,
  output logic                      ib_flush_r,
  output logic                      settings_restore_r
);
  // ==========================================
  // initialization events
  logic po;
  logic rc;
  logic cs;
  logic dc;
  assign po = init.power_on;
  assign rc = init.rst_cmd;
  assign cs = init.cls_cmd;
  assign dc = init.dev_clr;

  // status byte: hardware set wins over every clear
  logic [7:0] sb_clr;
  always_comb begin
    sb_clr = 8'h00;
    if (po) begin
      sb_clr = 8'hff;
    end
    if (cs) begin
      sb_clr = sb_clr | ~(8'h01 << `RRFI_MAV_BIT);
    end
    if (dc) begin
      sb_clr[`RRFI_MAV_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_byte_r <= `RRFI_SB_RST;
    end else begin
      status_byte_r <= (status_byte_r & ~sb_clr) | sb_set;
    end
  end

  // event register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      event_r <= `RRFI_EVT_RST;
    end else if (po) begin
      event_r <= (8'h01 << `RRFI_PON_BIT) | evt_set;
    end else if (cs) begin
      event_r <= evt_set;
    end else begin
      event_r <= event_r | evt_set;
    end
  end

  // enable registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sre_r <= `RRFI_ENA_RST;
      ese_r <= `RRFI_ENA_RST;
    end else if (po) begin
      sre_r <= `RRFI_ENA_RST;
      ese_r <= `RRFI_ENA_RST;
    end else begin
      if (sre_we) begin
        sre_r <= ena_wdata;
      end
      if (ese_we) begin
        ese_r <= ena_wdata;
      end
    end
  end

  // header flag
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      header_r <= `RRFI_HDR_RST;
    end else if (po || rc) begin
      header_r <= `RRFI_HDR_RST;
    end else if (hdr_we) begin
      header_r <= hdr_wdata;
    end
  end

  // command path position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      path_r <= PATH_W'(`RRFI_PATH_RST);
    end else if (po || dc) begin
      path_r <= PATH_W'(`RRFI_PATH_RST);
    end else if (path_we) begin
      path_r <= path_wdata;
    end
  end

  // flush and restore strobes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oq_flush_r         <= 1'b0;
      ib_flush_r         <= 1'b0;
      settings_restore_r <= 1'b0;
    end else begin
      oq_flush_r         <= po | dc;
      ib_flush_r         <= po | dc;
      settings_restore_r <= rc;
    end
  end

  // ==========================================
  // reply formatter
  function automatic logic [`RRFI_MAX_CHARS*8+3:0] build(input rrfi_pkg::rrfi_value_s v);
    logic [`RRFI_MAX_CHARS*8-1:0] s;
    logic [3:0]                   n;
    logic [2:0]                   nd;
    logic [2:0]                   dp;
    logic                         sgn;
    logic                         ex;
    logic [3:0]                   d;
    s   = '0;
    n   = 4'h0;
    nd  = 3'(`RRFI_DIGITS);
    dp  = 3'h0;
    sgn = 1'b1;
    ex  = 1'b0;
    case (v.kind)
      rrfi_pkg::RRFI_LOAD_COEF: begin
        sgn = 1'b0;
        dp  = (v.dp_pos == 3'h0 || v.dp_pos > 3'(`RRFI_DIGITS)) ? 3'h1 : v.dp_pos;
      end
      rrfi_pkg::RRFI_LOAD_D: begin
        dp = 3'(`RRFI_DIGITS - `RRFI_D_FRAC);
      end
      rrfi_pkg::RRFI_C_OFFSET: begin
        dp = 3'h1;
        ex = 1'b1;
      end
      rrfi_pkg::RRFI_DQ_OFFSET: begin
        dp = 3'(`RRFI_DIGITS - `RRFI_DQ_FRAC);
      end
      rrfi_pkg::RRFI_PCT_C: begin
        nd = 3'(`RRFI_PCT_DIGITS);
        dp = 3'(`RRFI_PCT_DIGITS - `RRFI_PCT_FRAC);
      end
      rrfi_pkg::RRFI_PCT_D: begin
        dp = 3'h0;
      end
      rrfi_pkg::RRFI_COUNT: begin
        dp = 3'h0;
      end
      default: begin
        dp = 3'h0;
      end
    endcase
    if (sgn && v.neg) begin
      s[n*8 +: 8] = `RRFI_CH_MINUS;
      n = n + 4'h1;
    end
    for (int i = 0; i < `RRFI_DIGITS; i++) begin
      if (3'(i) < nd) begin
        d = v.digits[(int'(nd) - 1 - i)*4 +: 4];
        s[n*8 +: 8] = `RRFI_CH_ZERO + {4'h0, d};
        n = n + 4'h1;
        if (dp != 3'h0 && 3'(i + 1) == dp) begin
          s[n*8 +: 8] = `RRFI_CH_POINT;
          n = n + 4'h1;
        end
      end
    end
    if (ex) begin
      s[n*8 +: 8] = `RRFI_CH_EXP;
      n = n + 4'h1;
      s[n*8 +: 8] = v.exp_neg ? `RRFI_CH_MINUS : `RRFI_CH_PLUS;
      n = n + 4'h1;
      s[n*8 +: 8] = `RRFI_CH_ZERO + {4'h0, v.exponent[7:4]};
      n = n + 4'h1;
      s[n*8 +: 8] = `RRFI_CH_ZERO + {4'h0, v.exponent[3:0]};
      n = n + 4'h1;
    end
    build = {n, s};
  endfunction : build

  rrfi_pkg::rrfi_state_e        state_r;
  logic [`RRFI_MAX_CHARS*8-1:0] text_r;
  logic [3:0]                   len_r;
  logic [3:0]                   idx_r;
  logic [`RRFI_MAX_CHARS*8+3:0] built;

  assign built     = build(fmt_value);
  assign fmt_ready = (state_r == rrfi_pkg::RRFI_IDLE);
  assign out_valid = (state_r == rrfi_pkg::RRFI_SEND);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= rrfi_pkg::RRFI_IDLE;
      text_r  <= '0;
      len_r   <= 4'h0;
      idx_r   <= 4'h0;
    end else begin
      case (state_r)
        rrfi_pkg::RRFI_IDLE: begin
          if (fmt_valid) begin
            text_r  <= built[`RRFI_MAX_CHARS*8-1:0];
            len_r   <= built[`RRFI_MAX_CHARS*8+3 -: 4];
            idx_r   <= 4'h0;
            state_r <= rrfi_pkg::RRFI_SEND;
          end
        end
        rrfi_pkg::RRFI_SEND: begin
          if (out_ready) begin
            idx_r <= idx_r + 4'h1;
            if (idx_r + 4'h1 == len_r) begin
              state_r <= rrfi_pkg::RRFI_IDLE;
            end
          end
        end
        default: begin
          state_r <= rrfi_pkg::RRFI_IDLE;
        end
      endcase
    end
  end

  assign out_char.ch   = text_r[idx_r*8 +: 8];
  assign out_char.last = out_valid && (idx_r + 4'h1 == len_r);

  // kind of the reply in flight
  rrfi_pkg::rrfi_kind_e kind_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kind_r <= rrfi_pkg::RRFI_LOAD_COEF;
    end else if (fmt_valid && fmt_ready) begin
      kind_r <= fmt_value.kind;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_pon_kept: assert property (po |=> event_r[`RRFI_PON_BIT])
    else $error("power-on bit not set after power-on");
  a_po_clears: assert property (po && evt_set == 8'h00 |=> event_r == 8'h80 && sre_r == 8'h00 && ese_r == 8'h00)
    else $error("power-on did not clear event or enable registers");
  a_rst_header: assert property (rc |=> header_r == `RRFI_HDR_RST && settings_restore_r)
    else $error("reset command did not restore header or settings");
  a_rst_keeps: assert property (rc && !po && !cs && !dc && sb_set == 8'h00 && evt_set == 8'h00
    |=> $stable(status_byte_r) && $stable(event_r) && !oq_flush_r)
    else $error("reset command disturbed interface state");
  a_cls_mav: assert property (cs && !po && !dc
    |=> status_byte_r[`RRFI_MAV_BIT] == $past(status_byte_r[`RRFI_MAV_BIT]) || $past(sb_set[`RRFI_MAV_BIT]))
    else $error("clear-status changed message-available");
  a_cls_events: assert property (cs && !po && evt_set == 8'h00 |=> event_r == 8'h00)
    else $error("clear-status left event bits");
  a_dc_clear: assert property (dc && !po && !sb_set[`RRFI_MAV_BIT]
    |=> !status_byte_r[`RRFI_MAV_BIT] && oq_flush_r && ib_flush_r && path_r == '0)
    else $error("device clear incomplete");
  a_dc_keeps: assert property (dc && !po && !cs && evt_set == 8'h00 |=> $stable(event_r))
    else $error("device clear changed events");
  a_coef_nosign: assert property (fmt_valid && fmt_ready && fmt_value.kind == rrfi_pkg::RRFI_LOAD_COEF
    |=> out_char.ch != `RRFI_CH_MINUS && len_r == 4'h7)
    else $error("coefficient reply has sign or wrong length");
  a_c_off_len: assert property (fmt_valid && fmt_ready && fmt_value.kind == rrfi_pkg::RRFI_C_OFFSET
    |=> len_r == ($past(fmt_value.neg) ? 4'hc : 4'hb))
    else $error("offset reply length wrong");
  a_count_nopoint: assert property (out_valid && kind_r == rrfi_pkg::RRFI_COUNT
    |-> out_char.ch != `RRFI_CH_POINT)
    else $error("integer reply carries a point");
  a_pct_d_int: assert property (out_valid && kind_r == rrfi_pkg::RRFI_PCT_D
    |-> out_char.ch != `RRFI_CH_POINT)
    else $error("percent D limit reply carries a point");
  a_load_d_len: assert property (fmt_valid && fmt_ready && fmt_value.kind == rrfi_pkg::RRFI_LOAD_D
    |=> len_r == ($past(fmt_value.neg) ? 4'h8 : 4'h7))
    else $error("load D reply length wrong");
  a_dq_off_len: assert property (fmt_valid && fmt_ready && fmt_value.kind == rrfi_pkg::RRFI_DQ_OFFSET
    |=> len_r == ($past(fmt_value.neg) ? 4'h8 : 4'h7))
    else $error("D or Q offset reply length wrong");
  a_pct_c_len: assert property (fmt_valid && fmt_ready && fmt_value.kind == rrfi_pkg::RRFI_PCT_C
    |=> len_r == ($past(fmt_value.neg) ? 4'h7 : 4'h6))
    else $error("percent C limit reply length wrong");
endmodule : rrfi_top

// file: tb/rrfi_host.sv
`timescale 1ns/1ps
// ==========================================
// host sink: takes reply chars, stalls every other cycle on demand
module rrfi_host (
  input  wire logic                 clock,
  input  wire logic                 stall,
  input  wire logic                 out_valid,
  output logic                      out_ready,
  input  wire rrfi_pkg::rrfi_char_s out_char
);
  logic [95:0] rx_r;
  logic        done_r;
  logic        cnt_r;

  initial begin
    out_ready = 1'b0;
    rx_r      = '0;
    done_r    = 1'b1;
    cnt_r     = 1'b0;
  end

  always @(negedge clock) begin
    cnt_r     <= ~cnt_r;
    out_ready <= !stall || cnt_r;
  end

  // collects one reply, a new reply starts after a last char
  always @(posedge clock) begin
    if (out_valid && out_ready) begin
      rx_r   <= done_r ? {88'h0, out_char.ch} : {rx_r[87:0], out_char.ch};
      done_r <= out_char.last;
    end
  end
endmodule : rrfi_host

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  rrfi_pkg::rrfi_init_s  init  = '0;
  logic [7:0]            sb_set = 8'h00, evt_set = 8'h00, ena_wdata = 8'h00;
  logic                  sre_we = 1'b0, ese_we = 1'b0, hdr_we = 1'b0, hdr_wdata = 1'b0, path_we = 1'b0;
  logic [3:0]            path_wdata = 4'h0;
  logic                  fmt_valid = 1'b0, stall = 1'b0;
  rrfi_pkg::rrfi_value_s fmt_value = '0;
  logic                  fmt_ready, out_valid, out_ready;
  rrfi_pkg::rrfi_char_s  out_char;
  logic [7:0]            status_byte_r, event_r, sre_r, ese_r;
  logic                  header_r, oq_flush_r, ib_flush_r, settings_restore_r;
  logic [3:0]            path_r;
  int                    num_errors = 0;
  int                    check_count = 0;

  always #25 clock = ~clock;

  rrfi_top #(.PATH_W(4)) i_dut (.clock(clock), .rst_n(rst_n), .init(init), .sb_set(sb_set), .evt_set(evt_set),
    .sre_we(sre_we), .ese_we(ese_we), .ena_wdata(ena_wdata), .hdr_we(hdr_we), .hdr_wdata(hdr_wdata),
    .path_we(path_we), .path_wdata(path_wdata), .fmt_valid(fmt_valid), .fmt_ready(fmt_ready),
    .fmt_value(fmt_value), .out_valid(out_valid), .out_ready(out_ready), .out_char(out_char),
    .status_byte_r(status_byte_r), .event_r(event_r), .sre_r(sre_r), .ese_r(ese_r), .header_r(header_r),
    .path_r(path_r), .oq_flush_r(oq_flush_r), .ib_flush_r(ib_flush_r), .settings_restore_r(settings_restore_r));

  rrfi_host i_host (.clock(clock), .stall(stall), .out_valid(out_valid), .out_ready(out_ready),
    .out_char(out_char));

  // ==========================================
  // checking and closing
  task check(input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // ==========================================
  // access tasks
  task fmt(input rrfi_pkg::rrfi_kind_e k, input logic n, input logic [23:0] d, input logic [2:0] p,
           input logic en, input logic [7:0] e, input logic [95:0] x);
    int i;
    @(negedge clock);
    fmt_value = '{k, n, d, p, en, e};
    fmt_valid = 1'b1;
    @(negedge clock);
    fmt_valid = 1'b0;
    for (i = 0; i < 80 && fmt_ready !== 1'b1; i++) @(negedge clock);
    if (fmt_ready !== 1'b1) num_errors++;
    check(i_host.rx_r, x);
    stall = ~stall;
  endtask : fmt

  task load;
    @(negedge clock);
    {sb_set, evt_set, ena_wdata, path_wdata} = {8'hff, 8'h7f, 8'h5a, 4'h9};
    {sre_we, ese_we, hdr_we, hdr_wdata, path_we} = 5'h1f;
    @(negedge clock);
    {sb_set, evt_set, sre_we, ese_we, hdr_we, hdr_wdata, path_we} = '0;
  endtask : load

  task ev(input logic [3:0] v, input logic [39:0] x);
    load();
    @(negedge clock);
    init = v;
    @(negedge clock);
    init = '0;
    check({status_byte_r, event_r, sre_r, ese_r, header_r, path_r, oq_flush_r, ib_flush_r, settings_restore_r}, x);
  endtask : ev

  // ==========================================
  // tests
  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    check({status_byte_r, event_r, sre_r, ese_r, header_r, path_r}, {8'h00, 8'h80, 8'h00, 8'h00, 1'b0, 4'h0});
    fmt(rrfi_pkg::RRFI_LOAD_COEF, 1'b0, 24'h123456, 3'h3, 1'b0, 8'h00, "123.456");
    fmt(rrfi_pkg::RRFI_LOAD_COEF, 1'b1, 24'h123456, 3'h7, 1'b0, 8'h00, "1.23456");
    fmt(rrfi_pkg::RRFI_LOAD_D, 1'b1, 24'h012345, 3'h0, 1'b0, 8'h00, "-0.12345");
    fmt(rrfi_pkg::RRFI_LOAD_D, 1'b0, 24'h900001, 3'h0, 1'b0, 8'h00, "9.00001");
    fmt(rrfi_pkg::RRFI_C_OFFSET, 1'b1, 24'h123456, 3'h0, 1'b1, 8'h12, "-1.23456E-12");
    fmt(rrfi_pkg::RRFI_C_OFFSET, 1'b0, 24'h987654, 3'h0, 1'b0, 8'h03, "9.87654E+03");
    fmt(rrfi_pkg::RRFI_DQ_OFFSET, 1'b1, 24'h123456, 3'h0, 1'b0, 8'h00, "-12345.6");
    fmt(rrfi_pkg::RRFI_PCT_C, 1'b1, 24'h012345, 3'h0, 1'b0, 8'h00, "-123.45");
    fmt(rrfi_pkg::RRFI_PCT_C, 1'b0, 24'h000005, 3'h0, 1'b0, 8'h00, "000.05");
    fmt(rrfi_pkg::RRFI_PCT_D, 1'b1, 24'h000123, 3'h0, 1'b0, 8'h00, "-000123");
    fmt(rrfi_pkg::RRFI_COUNT, 1'b0, 24'h999999, 3'h0, 1'b0, 8'h00, "999999");
    ev(4'h2, {8'h10, 8'h00, 8'h5a, 8'h5a, 1'b1, 4'h9, 3'h0});
    ev(4'h1, {8'hef, 8'h7f, 8'h5a, 8'h5a, 1'b1, 4'h0, 3'h6});
    ev(4'h4, {8'hff, 8'h7f, 8'h5a, 8'h5a, 1'b0, 4'h9, 3'h1});
    ev(4'h8, {8'h00, 8'h80, 8'h00, 8'h00, 1'b0, 4'h0, 3'h6});
    conclude();
  end

  initial begin
    #(3000 * 50);
    num_errors++;
    conclude();
  end
endmodule : tb
